// ### shared/sdram_pkg.sv
// Shared constants and carriers for the DRAM command and read-data engine.
// Assumes a four-bank part with commands taken on rising edges of the memory clock.
package sdram_pkg;

   localparam int unsigned BANKS          = 4;
   localparam int unsigned BANK_W         = 2;
   localparam int unsigned ROW_W          = 14;
   localparam int unsigned COL_W          = 10;
   localparam int unsigned DQ_W           = 8;
   localparam int unsigned AUTOPRE_BIT    = 10;

   // Command codes, {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_LOAD_MODE   = 4'h0;
   localparam logic [3:0] CMD_REFRESH     = 4'h1;
   localparam logic [3:0] CMD_PRECHARGE   = 4'h2;
   localparam logic [3:0] CMD_ACTIVATE    = 4'h3;
   localparam logic [3:0] CMD_WRITE       = 4'h4;
   localparam logic [3:0] CMD_READ        = 4'h5;
   localparam logic [3:0] CMD_BURST_STOP  = 4'h6;
   localparam logic [3:0] CMD_NOP         = 4'h7;

   // Read latency in half clock periods: 4 = two cycles, 5 = two and a half
   localparam int unsigned MAX_LAT_HALF   = 6;
   localparam logic [2:0]  LAT_HALF_MIN   = 3'h4;
   localparam logic [2:0]  LAT_HALF_RESET = 3'h4;
   localparam logic [3:0]  BURST_RESET    = 4'h4;

   // DLL relock window after self refresh exit, in memory clock cycles
   localparam int unsigned DLL_RELOCK_CYCLES = 200;
   localparam logic [7:0]  DLL_RELOCK_COUNT  = 8'(DLL_RELOCK_CYCLES);

   typedef struct packed {
      logic              ck;
      logic              ck_n;
      logic              cke;
      logic [3:0]        code;
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  addr;
   } pin_cmd_t;

   typedef struct packed {
      logic              rd;
      logic              stop;
      logic              all;
      logic              apre;
      logic [BANK_W-1:0] bank;
      logic [COL_W-1:0]  col;
   } read_evt_t;

   typedef struct packed {
      logic [DQ_W-1:0]   data;
      logic              strobe;
   } elem_t;

   typedef enum logic {
      mode_normal,
      mode_self_refresh
   } mode_t;

endpackage : sdram_pkg

// ### logic/elem_buffer.sv
// Small valid/ready buffer between the burst generator and the pin stage.
// Assumes both sides run on the same clock; depth and width are structural.
`timescale 1ns/100ps

module elem_buffer #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             i_clock,
   input  wire logic             i_resetn,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
      $error("elem_buffer: DEPTH must be at least 2 and WIDTH at least 1");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;

   wire push = i_in_valid & o_in_ready;
   wire pop  = o_out_valid & i_out_ready;

   assign o_in_ready  = (count_r != CW'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];

   wire [PW-1:0] wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
   wire [PW-1:0] rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_nxt;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_nxt;
         end
         if (push && !pop) begin
            count_r <= count_r + CW'(1);
         end else if (pop && !push) begin
            count_r <= count_r - CW'(1);
         end
      end
   end

   // Storage needs no reset; count guards every read
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

endmodule : elem_buffer

// ### logic/sdram_read_engine.sv
// Device-side command decode, self refresh, row tracking and read data engine.
// Assumes the memory clock pins are far slower than i_clock and are sampled here.
`timescale 1ns/100ps

module sdram_read_engine
   import sdram_pkg::*;
#(
   parameter int unsigned BUF_DEPTH = 2
) (
   input  wire logic              i_clock,
   input  wire logic              i_resetn,
   input  wire logic              i_mem_clock,
   input  wire logic              i_clock_complement,
   input  wire logic              i_cke,
   input  wire logic              i_cs_n,
   input  wire logic              i_ras_n,
   input  wire logic              i_cas_n,
   input  wire logic              i_we_n,
   input  wire logic [BANK_W-1:0] i_bank,
   input  wire logic [ROW_W-1:0]  i_addr,
   input  wire logic [2:0]        i_read_latency_half,
   input  wire logic [3:0]        i_burst_len,
   output logic [DQ_W-1:0]        o_dq,
   output logic                   o_dq_oe,
   output logic                   o_dqs,
   output logic                   o_dqs_oe,
   output logic                   o_self_refresh,
   output logic                   o_dll_locked,
   output logic [BANKS-1:0]       o_bank_open
);

   if (BUF_DEPTH < 2) begin : g_bad_depth
      $error("sdram_read_engine: BUF_DEPTH must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; clock pins travel with the command so edges line up
   pin_cmd_t pin_raw;
   pin_cmd_t meta_r;
   pin_cmd_t pin_r;
   logic     diff_d_r;

   assign pin_raw = '{ck: i_mem_clock, ck_n: i_clock_complement, cke: i_cke,
                      code: {i_cs_n, i_ras_n, i_cas_n, i_we_n}, bank: i_bank, addr: i_addr};

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_r   <= '0;
         pin_r    <= '0;
         diff_d_r <= 1'b0;
      end else begin
         meta_r   <= pin_raw;
         pin_r    <= meta_r;
         diff_d_r <= pin_r.ck & ~pin_r.ck_n;
      end
   end

   wire diff_hi   = pin_r.ck & ~pin_r.ck_n;
   wire rise      = diff_hi & ~diff_d_r;
   wire fall      = ~diff_hi & diff_d_r;
   wire half_edge = rise | fall;

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode
   mode_t            mode_r;
   logic [BANKS-1:0] open_r;
   logic [ROW_W-1:0] row_r [BANKS];
   logic [7:0]       dll_cnt_r;

   wire normal   = (mode_r == mode_normal);
   wire cmd_take = rise & normal & pin_r.cke;
   wire is_act   = cmd_take & (pin_r.code == CMD_ACTIVATE);
   wire is_read  = cmd_take & (pin_r.code == CMD_READ) & open_r[pin_r.bank];
   wire is_stop  = cmd_take & (pin_r.code == CMD_BURST_STOP);
   wire is_pre   = cmd_take & (pin_r.code == CMD_PRECHARGE);
   wire sr_enter = rise & normal & ~pin_r.cke & (pin_r.code == CMD_REFRESH);
   wire sr_exit  = ~normal & pin_r.cke;
   wire pre_all  = pin_r.addr[AUTOPRE_BIT];

   read_evt_t cap_evt;
   // Burst stop names no bank, so it ends whichever read is running
   assign cap_evt = '{rd: is_read, stop: is_stop | is_pre, all: is_stop | (is_pre & pre_all),
                      apre: pin_r.addr[AUTOPRE_BIT], bank: pin_r.bank,
                      col: pin_r.addr[COL_W-1:0]};

   ////////////////////////////////////////////////////////////////////////////////
   // Self refresh and DLL relock
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_r    <= mode_normal;
         dll_cnt_r <= DLL_RELOCK_COUNT;
      end else if (sr_enter) begin
         mode_r    <= mode_self_refresh;
         dll_cnt_r <= '0;
      end else if (sr_exit) begin
         mode_r    <= mode_normal;
      end else if (normal && rise && dll_cnt_r != DLL_RELOCK_COUNT) begin
         dll_cnt_r <= dll_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_self_refresh <= 1'b0;
         o_dll_locked   <= 1'b1;
         o_bank_open    <= '0;
      end else begin
         o_self_refresh <= ~normal;
         o_dll_locked   <= normal & (dll_cnt_r == DLL_RELOCK_COUNT);
         o_bank_open    <= open_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Latency line, one slot per half clock; taps pick the latency
   read_evt_t line_r [MAX_LAT_HALF];

   wire       lat_ok   = (i_read_latency_half >= LAT_HALF_MIN) &&
                         (i_read_latency_half <= 3'(MAX_LAT_HALF));
   wire [2:0] lat      = lat_ok ? i_read_latency_half : LAT_HALF_RESET;
   wire [2:0] prod_sel = lat - 3'h2;
   wire [2:0] pre_sel  = lat - 3'h3;
   read_evt_t tap_prod;
   read_evt_t tap_pre;
   assign tap_prod = line_r[prod_sel];
   assign tap_pre  = line_r[pre_sel];

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int j = 0; j < MAX_LAT_HALF; j++) begin
            line_r[j] <= '0;
         end
      end else if (half_edge) begin
         line_r[0] <= rise ? cap_evt : '0;
         for (int j = 1; j < MAX_LAT_HALF; j++) begin
            line_r[j] <= line_r[j-1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Burst generator, one element ahead of the pins
   logic              prod_active_r;
   logic [BANK_W-1:0] prod_bank_r;
   logic [COL_W-1:0]  prod_col_r;
   logic [3:0]        prod_left_r;
   logic              prod_apre_r;
   logic              prod_idx_r;
   logic              buf_in_ready;
   logic              buf_out_valid;
   elem_t             buf_out;
   elem_t             push_elem;

   wire       bl_ok    = (i_burst_len == 4'h2) || (i_burst_len == 4'h4) || (i_burst_len == 4'h8);
   wire [3:0] bl       = bl_ok ? i_burst_len : BURST_RESET;
   wire [COL_W-1:0] bl_mask = COL_W'(bl - 4'h1);
   wire       stop_hit = tap_prod.stop & (tap_prod.all | (tap_prod.bank == prod_bank_r));

   // A new read at the tap always wins: concatenation and interruption alike
   wire              load     = tap_prod.rd;
   wire [BANK_W-1:0] cur_bank = load ? tap_prod.bank : prod_bank_r;
   wire [COL_W-1:0]  cur_col  = load ? tap_prod.col  : prod_col_r;
   wire [3:0]        cur_left = load ? bl : prod_left_r;
   wire              cur_apre = load ? tap_prod.apre : prod_apre_r;
   wire              cur_idx  = load ? 1'b0 : prod_idx_r;
   wire [COL_W-1:0]  col_inc  = cur_col + COL_W'(1);
   wire [COL_W-1:0]  col_nxt  = (cur_col & ~bl_mask) | (col_inc & bl_mask);

   wire push_valid = half_edge & (load | (prod_active_r & ~stop_hit));
   wire advance    = push_valid & buf_in_ready;
   wire last_elem  = (cur_left == 4'h1);
   wire apre_close = advance & last_elem & cur_apre;

   // Stand-in array content: open row mixed with column
   assign push_elem = '{data: row_r[cur_bank][DQ_W-1:0] ^ cur_col[DQ_W-1:0],
                        strobe: ~cur_idx};

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         prod_active_r <= 1'b0;
         prod_bank_r   <= '0;
         prod_col_r    <= '0;
         prod_left_r   <= '0;
         prod_apre_r   <= 1'b0;
         prod_idx_r    <= 1'b0;
      end else if (advance) begin
         prod_active_r <= ~last_elem;
         prod_bank_r   <= cur_bank;
         prod_col_r    <= col_nxt;
         prod_left_r   <= cur_left - 4'h1;
         prod_apre_r   <= cur_apre;
         prod_idx_r    <= ~cur_idx;
      end else if (half_edge && stop_hit && !load) begin
         prod_active_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bank rows
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         open_r <= '0;
         for (int b = 0; b < BANKS; b++) begin
            row_r[b] <= '0;
         end
      end else begin
         if (apre_close) begin
            open_r[prod_bank_r] <= 1'b0;
         end
         if (is_pre && pre_all) begin
            open_r <= '0;
         end else if (is_pre) begin
            open_r[pin_r.bank] <= 1'b0;
         end
         if (is_act) begin
            open_r[pin_r.bank] <= 1'b1;
            row_r[pin_r.bank]  <= pin_r.addr;
         end
      end
   end

   elem_buffer #(
      .WIDTH ($bits(elem_t)),
      .DEPTH (BUF_DEPTH)
   ) u_buffer (
      .i_clock     (i_clock),
      .i_resetn    (i_resetn),
      .i_in_valid  (push_valid),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (push_elem),
      .o_out_valid (buf_out_valid),
      .i_out_ready (half_edge),
      .o_out_data  (buf_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Pin stage: one element per clock crossing
   wire preamble = tap_pre.rd | tap_prod.rd;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dq     <= '0;
         o_dq_oe  <= 1'b0;
         o_dqs    <= 1'b0;
         o_dqs_oe <= 1'b0;
      end else if (half_edge) begin
         if (buf_out_valid) begin
            o_dq     <= buf_out.data;
            o_dq_oe  <= 1'b1;
            o_dqs    <= buf_out.strobe;
            o_dqs_oe <= 1'b1;
         end else if (preamble) begin
            o_dq_oe  <= 1'b0;
            o_dqs    <= 1'b0;
            o_dqs_oe <= 1'b1;
         end else begin
            o_dq_oe  <= 1'b0;
            o_dqs    <= 1'b0;
            o_dqs_oe <= 1'b0;
         end
      end
   end

endmodule : sdram_read_engine

// ### verification/sdram_read_engine_asserts.sv
// Checker for the read engine: strobe framing and self refresh.
// Assumes it is bound to every sdram_read_engine instance.
`timescale 1ns/100ps

module sdram_read_engine_checker
   import sdram_pkg::*;
(
   input  wire logic            i_clock,
   input  wire logic            i_resetn,
   input  wire logic            i_cke,
   input  wire logic [DQ_W-1:0] o_dq,
   input  wire logic            o_dq_oe,
   input  wire logic            o_dqs,
   input  wire logic            o_dqs_oe,
   input  wire logic            o_self_refresh,
   input  wire logic            o_dll_locked
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   ////////////////////////////////////////////////////////////
   property p_oe_pair; o_dq_oe |-> o_dqs_oe; endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("data without strobe");
   property p_pre; $rose(o_dqs_oe) |-> (!o_dq_oe && !o_dqs) [*6]; endproperty
   a_pre: assert property (p_pre) else $error("short preamble");
   property p_first; $rose(o_dq_oe) |-> o_dqs && $past(o_dqs_oe); endproperty
   a_first: assert property (p_first) else $error("bad first strobe");
   property p_post; $fell(o_dq_oe) |-> !$past(o_dqs) && !o_dqs_oe; endproperty
   a_post: assert property (p_post) else $error("bad postamble");
   property p_stand; $rose(o_dq_oe) |=> $stable(o_dq) [*2]; endproperty
   a_stand: assert property (p_stand) else $error("element too short");
   property p_sr_dll; o_self_refresh && $past(o_self_refresh) |-> !o_dll_locked; endproperty
   a_sr_dll: assert property (p_sr_dll) else $error("dll on in self refresh");
   property p_sr_exit; $fell(o_self_refresh) |=> !o_dll_locked [*8]; endproperty
   a_sr_exit: assert property (p_sr_exit) else $error("dll locked too soon");
   property p_exit_cke; o_self_refresh && i_cke |-> ##[1:5] !o_self_refresh; endproperty
   a_exit_cke: assert property (p_exit_cke) else $error("no exit on gate");
endmodule : sdram_read_engine_checker

bind sdram_read_engine sdram_read_engine_checker chk_i (
   .i_clock(i_clock), .i_resetn(i_resetn), .i_cke(i_cke), .o_dq(o_dq),
   .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe),
   .o_self_refresh(o_self_refresh), .o_dll_locked(o_dll_locked));

// ### verification/mem_ctrl_model.sv
// Memory controller model: free-running memory clock and command pins.
// Assumes one bench process calls its tasks.
`timescale 1ns/100ps

module mem_ctrl_model
   import sdram_pkg::*;
(
   input  wire logic i_clock,
   output pin_cmd_t  o_pins
);
   // Each pin group has a single writer; the clock runs from its own process
   logic              ck_r   = 1'b0;
   logic              cke_r  = 1'b1;
   logic [3:0]        code_r = CMD_NOP;
   logic [BANK_W-1:0] bank_r = '0;
   logic [ROW_W-1:0]  addr_r = '0;

   assign o_pins = '{ck: ck_r, ck_n: ~ck_r, cke: cke_r, code: code_r, bank: bank_r,
                     addr: addr_r};

   initial begin
      #137;
      forever begin
         #200 ck_r = ~ck_r;
      end
   end
   ////////////////////////////////////////////////////////////
   // Pins change half a clock before the rise and hold across it
   task automatic cmd(input logic [3:0] c, input logic [1:0] b = 2'h0,
                      input logic [13:0] a = 14'h0000);
      @(negedge ck_r);
      @(posedge i_clock);
      code_r <= c;
      // Idle lines toggle so a stale value never looks valid
      bank_r <= (c >= CMD_NOP) ? ~bank_r : b;
      addr_r <= (c >= CMD_NOP) ? ~addr_r : a;
      @(posedge ck_r);
   endtask : cmd

   task automatic idle(input int n);
      for (int i = 0; i < n; i++) cmd(i[0] ? 4'hF : CMD_NOP);
   endtask : idle

   task automatic set_cke(input logic v);
      @(posedge i_clock);
      cke_r <= v;
   endtask : set_cke
endmodule : mem_ctrl_model

// ### verification/testbench.sv
// Bench: controller model drives commands, a monitor collects read elements.
// Assumes 20 MHz system clock and a 400 ns memory clock.
`timescale 1ns/100ps

module testbench;
   import sdram_pkg::*;
   logic             i_clock, i_resetn, o_dq_oe, o_dqs, o_dqs_oe;
   logic             o_self_refresh, o_dll_locked, oe_q, dqs_q;
   logic [2:0]       lat;
   logic [3:0]       bl;
   logic [DQ_W-1:0]  o_dq;
   logic [BANKS-1:0] o_bank_open;
   wire pin_cmd_t    pins;
   elem_t            q[$];
   int               n_fail, num_checks;
   realtime          t_rd, t_first;

   sdram_read_engine #(.BUF_DEPTH(2)) uut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_mem_clock(pins.ck),
      .i_clock_complement(pins.ck_n), .i_cke(pins.cke), .i_cs_n(pins.code[3]),
      .i_ras_n(pins.code[2]), .i_cas_n(pins.code[1]), .i_we_n(pins.code[0]),
      .i_bank(pins.bank), .i_addr(pins.addr), .i_read_latency_half(lat),
      .i_burst_len(bl), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs),
      .o_dqs_oe(o_dqs_oe), .o_self_refresh(o_self_refresh),
      .o_dll_locked(o_dll_locked), .o_bank_open(o_bank_open));
   mem_ctrl_model ctrl (.i_clock(i_clock), .o_pins(pins));

   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   // One element per strobe change while data is driven; sampled mid-cycle
   always @(negedge i_clock) begin
      if (o_dq_oe && (!oe_q || o_dqs !== dqs_q)) begin
         q.push_back('{data: o_dq, strobe: o_dqs});
         if (!oe_q) t_first = $realtime;
      end
      oe_q = o_dq_oe;
      dqs_q = o_dqs;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Columns wrap inside the burst-aligned block
   task automatic seg(input logic [7:0] row, input int c0, input int b, input int n);
      elem_t e;
      int    c;
      for (int i = 0; i < n; i++) begin
         c = (c0 & ~(b - 1)) | ((c0 + i) & (b - 1));
         e = (q.size() > 0) ? q.pop_front() : elem_t'('1);
         chk({e.data, 7'h00, e.strobe}, {row ^ c[7:0], 7'h00, ~i[0]});
      end
   endtask : seg

   task automatic rd(input logic [1:0] b, input int c, input logic ap);
      ctrl.cmd(CMD_READ, b, {3'h0, ap, 10'(c)});
      t_rd = $realtime;
   endtask : rd

   task automatic t_modes();
      ctrl.cmd(CMD_ACTIVATE, 2'h1, 14'h00A5);
      ctrl.idle(2);
      for (int l = 4; l <= 6; l++) for (int k = 1; k <= 3; k++) begin
         lat <= 3'(l);
         bl <= 4'(1 << k);
         q.delete();
         ctrl.idle(1);
         rd(2'h1, 3, 1'b0);
         ctrl.idle(9);
         seg(8'hA5, 3, 1 << k, 1 << k);
         chk(16'(q.size()), 16'h0000);
         chk({o_dq_oe, o_dqs_oe}, 16'h0000);
         chk(16'(t_first - t_rd >= l * 200 && t_first - t_rd <= l * 200 + 250), 16'h0001);
      end
   endtask : t_modes

   task automatic t_concat();
      lat <= 3'h4;
      bl <= 4'h8;
      ctrl.idle(1);
      rd(2'h1, 0, 1'b0);
      rd(2'h1, 4, 1'b0);
      ctrl.idle(8);
      seg(8'hA5, 0, 8, 2);
      seg(8'hA5, 4, 8, 8);
      bl <= 4'h4;
      rd(2'h1, 0, 1'b0);
      ctrl.idle(1);
      rd(2'h1, 8, 1'b0);
      ctrl.idle(8);
      seg(8'hA5, 0, 4, 4);
      seg(8'hA5, 8, 4, 4);
      chk(16'(q.size()), 16'h0000);
   endtask : t_concat

   task automatic t_stop();
      bl <= 4'h8;
      rd(2'h1, 0, 1'b0);
      ctrl.cmd(CMD_BURST_STOP);
      ctrl.idle(8);
      seg(8'hA5, 0, 8, 2);
      chk(16'(q.size()), 16'h0000);
      chk(o_bank_open, 16'h0002);
      rd(2'h1, 0, 1'b0);
      ctrl.idle(1);
      ctrl.cmd(CMD_PRECHARGE, 2'h1, 14'h0000);
      ctrl.idle(8);
      seg(8'hA5, 0, 8, 4);
      chk(16'(q.size()), 16'h0000);
      chk(o_bank_open, 16'h0000);
   endtask : t_stop

   task automatic t_autopre();
      bl <= 4'h4;
      ctrl.cmd(CMD_ACTIVATE, 2'h2, 14'h013C);
      ctrl.idle(2);
      rd(2'h2, 5, 1'b1);
      ctrl.idle(8);
      seg(8'h3C, 5, 4, 4);
      chk(o_bank_open, 16'h0000);
      rd(2'h2, 0, 1'b0);
      ctrl.idle(8);
      chk(16'(q.size()), 16'h0000);
   endtask : t_autopre

   task automatic t_selfref();
      ctrl.set_cke(1'b0);
      ctrl.cmd(CMD_REFRESH);
      ctrl.idle(1);
      chk({o_self_refresh, o_dll_locked}, 16'h0002);
      ctrl.cmd(CMD_ACTIVATE, 2'h0, 14'h0011);
      ctrl.cmd(CMD_READ);
      ctrl.idle(6);
      chk({q.size() > 0, o_bank_open}, 16'h0000);
      ctrl.set_cke(1'b1);
      ctrl.idle(2);
      chk({o_self_refresh, o_dll_locked}, 16'h0000);
      ctrl.idle(190);
      chk(o_dll_locked, 16'h0000);
      ctrl.idle(12);
      chk(o_dll_locked, 16'h0001);
      ctrl.cmd(CMD_ACTIVATE, 2'h3, 14'h0011);
      ctrl.idle(2);
      rd(2'h3, 1, 1'b0);
      ctrl.idle(8);
      seg(8'h11, 1, 4, 4);
      ctrl.cmd(CMD_PRECHARGE, 2'h0, 14'h0400);
      ctrl.idle(1);
      chk(o_bank_open, 16'h0000);
   endtask : t_selfref

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude

   initial begin
      i_resetn = 1'b0;
      lat = 3'h4;
      bl = 4'h4;
      oe_q = 1'b0;
      dqs_q = 1'b0;
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      @(posedge i_clock);
      #1 chk({o_dq_oe, o_dqs_oe, o_self_refresh, o_dll_locked, o_bank_open}, 16'h0010);
      t_modes();
      t_concat();
      t_stop();
      t_autopre();
      t_selfref();
      conclude();
   end

   initial begin
      #1_000_000;
      n_fail++;
      conclude();
   end
endmodule : testbench
